// ==== tapecs_cfg.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 tap event configuration and status bank.
 Assumes it is included by bare name from design files of the same folder.
*/
`ifndef TAPECS_CFG_SVH
`define TAPECS_CFG_SVH

// ============================================================
// Register word indices (byte address is four times the index)
`define TAPECS_OFS_CFG      6'h21
`define TAPECS_OFS_STATUS   6'h22
`define TAPECS_OFS_THR_X    6'h23
`define TAPECS_OFS_THR_Y    6'h24
`define TAPECS_OFS_THR_Z    6'h25
`define TAPECS_OFS_TLIMIT   6'h26
`define TAPECS_OFS_LATENCY  6'h27

// ============================================================
// Configuration fields
`define TAPECS_CFG_ABORT    7
`define TAPECS_CFG_LATCH    6

// ============================================================
// Status fields
`define TAPECS_ST_ACTIVE    7
`define TAPECS_ST_HIT_LSB   4
`define TAPECS_ST_DOUBLE    3
`define TAPECS_ST_SIGN_LSB  0

// ============================================================
// Reset values and timing
`define TAPECS_RST_BYTE     8'h00
`define TAPECS_RST_LEVEL    7'h00
`define TAPECS_WINDOW_STEPS 8'h10

`endif

// ==== tapecs_pkg.sv ====
/*
 Types of the tap event configuration and status bank.
 Assumes nothing of its surroundings.
*/
package tapecs_pkg;

    // ============================================================
    // Per-axis detector
    typedef enum logic [2:0] {
        DET_IDLE   = 3'b000,
        DET_FIRST  = 3'b001,
        DET_LAT    = 3'b010,
        DET_WIN    = 3'b011,
        DET_SECOND = 3'b100,
        DET_HOLD   = 3'b101
    } tapecs_det_st_type;

    typedef struct packed {
        tapecs_det_st_type st;
        logic [7:0]        cnt;
        logic              in_pulse;
        logic              ended;
        logic              sign;
        logic              single;
        logic              dbl;
    } tapecs_det_type;

    // ============================================================
    // Register bank
    typedef struct packed {
        logic [7:0] cfg;
        logic [6:0] thr_x;
        logic [6:0] thr_y;
        logic [6:0] thr_z;
        logic [7:0] tlimit;
        logic [7:0] latency;
        logic [7:0] status;
        logic       wait_n;
        logic [7:0] rdata;
    } tapecs_top_type;

endpackage : tapecs_pkg

// ==== tapecs_axis_det.sv ====
/*
 Tap detector for one axis: finds single and double taps in a stream of
 signed acceleration samples.
 Assumes samples and the strobe come from logic on core_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tapecs_cfg.svh"

module tapecs_axis_det
    import tapecs_pkg::*;
#(
    parameter int ACCEL_W = 8
)
(
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               rst_i,
    // Samples
    input  wire logic               sample_valid_i,
    input  wire logic [ACCEL_W-1:0] accel_i,
    // Settings
    input  wire logic [6:0]         level_i,
    input  wire logic [7:0]         time_limit_i,
    input  wire logic [7:0]         latency_i,
    input  wire logic [7:0]         window_i,
    input  wire logic               abort_i,
    // Results
    output logic                    single_o,
    output logic                    double_o,
    output logic                    sign_o
);

    // ============================================================
    // Elaboration check
    if (ACCEL_W < 8)
    begin : g_bad_width
        $error("ACCEL_W must be at least 8");
    end

    // ============================================================
    // Magnitude compare
    logic [ACCEL_W-1:0] mag;
    logic               neg;
    logic               above;

    always_comb
    begin
        neg   = accel_i[ACCEL_W-1];
        mag   = neg ? ACCEL_W'(-accel_i) : accel_i;
        // Zero level leaves the axis idle; unsigned 7-bit level
        above = (level_i != `TAPECS_RST_LEVEL) && (mag[ACCEL_W-1 -: 8] > {1'b0, level_i});
    end

    // ============================================================
    // Detector state
    tapecs_det_type s;
    tapecs_det_type next_s;

    always_comb
    begin
        next_s        = s;
        next_s.single = 1'b0;
        next_s.dbl    = 1'b0;
        if (sample_valid_i)
        begin
            unique case (s.st)
                DET_IDLE:
                begin
                    if (above)
                    begin
                        next_s.st   = DET_FIRST;
                        next_s.cnt  = 8'h00;
                        next_s.sign = neg;
                    end
                end
                DET_FIRST, DET_SECOND:
                begin
                    if (!above)
                    begin
                        // Pulse valid only if it fell back within the limit
                        if (s.st == DET_FIRST)
                        begin
                            next_s.single   = 1'b1;
                            next_s.st       = DET_LAT;
                            next_s.in_pulse = 1'b0;
                            next_s.ended    = 1'b0;
                        end
                        else
                        begin
                            next_s.dbl = 1'b1;
                            next_s.st  = DET_IDLE;
                        end
                        next_s.cnt = 8'h00;
                    end
                    else if (s.cnt >= time_limit_i)
                    begin
                        next_s.st = DET_HOLD;
                    end
                    else
                    begin
                        next_s.cnt = s.cnt + 8'h01;
                    end
                end
                DET_LAT:
                begin
                    // Pulses here are ignored, only watched for the abort
                    if (above)
                    begin
                        next_s.in_pulse = 1'b1;
                    end
                    else if (s.in_pulse)
                    begin
                        next_s.ended = 1'b1;
                    end
                    if (s.cnt >= latency_i)
                    begin
                        next_s.cnt = 8'h00;
                        if (abort_i && s.ended)
                        begin
                            next_s.st = DET_IDLE;
                        end
                        else
                        begin
                            next_s.st = DET_WIN;
                        end
                    end
                    else
                    begin
                        next_s.cnt = s.cnt + 8'h01;
                    end
                end
                DET_WIN:
                begin
                    if (above)
                    begin
                        next_s.st   = DET_SECOND;
                        next_s.cnt  = 8'h00;
                        next_s.sign = neg;
                    end
                    else if (s.cnt >= window_i)
                    begin
                        next_s.st = DET_IDLE;
                    end
                    else
                    begin
                        next_s.cnt = s.cnt + 8'h01;
                    end
                end
                DET_HOLD:
                begin
                    if (!above)
                    begin
                        next_s.st = DET_IDLE;
                    end
                end
                default:
                begin
                    next_s.st = DET_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign single_o = s.single;
    assign double_o = s.dbl;
    assign sign_o   = s.sign;

endmodule : tapecs_axis_det
`default_nettype wire

// ==== tapecs_top.sv ====
/*
 Tap event configuration and status bank with three axis detectors,
 reached over an Avalon-MM slave with waitrequest.
 Assumes acceleration samples from logic on core_clk_i; the Avalon address
 is a word index, so a register's byte address is four times its index.
*/
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tapecs_cfg.svh"

module tapecs_top
    import tapecs_pkg::*;
#(
    parameter int         ACCEL_W      = 8,
    parameter logic [7:0] WINDOW_STEPS = `TAPECS_WINDOW_STEPS
)
(
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               rst_i,
    // Avalon-MM slave
    input  wire logic [5:0]         avs_address_i,
    input  wire logic               avs_read_i,
    input  wire logic               avs_write_i,
    input  wire logic [31:0]        avs_writedata_i,
    input  wire logic [3:0]         avs_byteenable_i,
    output logic      [31:0]        avs_readdata_o,
    output logic                    avs_waitrequest_o,
    // Samples
    input  wire logic               sample_valid_i,
    input  wire logic [ACCEL_W-1:0] accel_x_i,
    input  wire logic [ACCEL_W-1:0] accel_y_i,
    input  wire logic [ACCEL_W-1:0] accel_z_i,
    // Interrupt
    output logic                    tap_irq_o
);

    // ============================================================
    // Elaboration check
    if (WINDOW_STEPS == 8'h00)
    begin : g_bad_window
        $error("WINDOW_STEPS must be nonzero");
    end

    // ============================================================
    // Register read decode
    function automatic logic [7:0] reg_read(input tapecs_top_type r, input logic [5:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            `TAPECS_OFS_CFG:     d = r.cfg;
            `TAPECS_OFS_STATUS:  d = r.status;
            `TAPECS_OFS_THR_X:   d = {1'b0, r.thr_x};
            `TAPECS_OFS_THR_Y:   d = {1'b0, r.thr_y};
            `TAPECS_OFS_THR_Z:   d = {1'b0, r.thr_z};
            `TAPECS_OFS_TLIMIT:  d = r.tlimit;
            `TAPECS_OFS_LATENCY: d = r.latency;
            default:             d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    // ============================================================
    // Axis detectors
    tapecs_top_type      s;
    tapecs_top_type      next_s;
    logic [2:0]          det_single;
    logic [2:0]          det_double;
    logic [2:0]          det_sign;
    logic [ACCEL_W-1:0]  accel [3];
    logic [6:0]          level [3];

    always_comb
    begin
        accel[0] = accel_x_i;
        accel[1] = accel_y_i;
        accel[2] = accel_z_i;
        level[0] = s.thr_x;
        level[1] = s.thr_y;
        level[2] = s.thr_z;
    end

    for (genvar a = 0; a < 3; a++)
    begin : g_axis
        tapecs_axis_det #(
            .ACCEL_W        (ACCEL_W)
        ) u_det (
            .core_clk_i     (core_clk_i),
            .rst_i          (rst_i),
            .sample_valid_i (sample_valid_i),
            .accel_i        (accel[a]),
            .level_i        (level[a]),
            .time_limit_i   (s.tlimit),
            .latency_i      (s.latency),
            .window_i       (WINDOW_STEPS),
            .abort_i        (s.cfg[`TAPECS_CFG_ABORT]),
            .single_o       (det_single[a]),
            .double_o       (det_double[a]),
            .sign_o         (det_sign[a])
        );
    end

    // ============================================================
    // Event gating and bus decode
    logic [2:0] hit_single;
    logic [2:0] hit_double;
    logic [2:0] hit_axis;
    logic       any_hit;
    logic       req;
    logic       done;
    logic       wr_done;
    logic       rd_clear;
    logic [7:0] fresh;

    always_comb
    begin
        for (int a = 0; a < 3; a++)
        begin
            hit_single[a] = det_single[a] & s.cfg[2*a];
            hit_double[a] = det_double[a] & s.cfg[2*a+1];
        end
        hit_axis = hit_single | hit_double;
        any_hit  = |hit_axis;
        fresh    = {1'b1, hit_axis, |hit_double, hit_axis & det_sign};
        req      = avs_read_i | avs_write_i;
        // Answer one cycle after the request is seen
        done     = req & ~s.wait_n;
        wr_done  = done & avs_write_i & avs_byteenable_i[0];
        rd_clear = done & avs_read_i & (avs_address_i == `TAPECS_OFS_STATUS);
    end

    // ============================================================
    // Next state
    always_comb
    begin
        next_s        = s;
        next_s.wait_n = ~(req & s.wait_n);
        if (req && s.wait_n)
        begin
            next_s.rdata = reg_read(s, avs_address_i);
        end
        if (wr_done)
        begin
            unique case (avs_address_i)
                `TAPECS_OFS_CFG:     next_s.cfg     = avs_writedata_i[7:0];
                `TAPECS_OFS_THR_X:   next_s.thr_x   = avs_writedata_i[6:0];
                `TAPECS_OFS_THR_Y:   next_s.thr_y   = avs_writedata_i[6:0];
                `TAPECS_OFS_THR_Z:   next_s.thr_z   = avs_writedata_i[6:0];
                `TAPECS_OFS_TLIMIT:  next_s.tlimit  = avs_writedata_i[7:0];
                `TAPECS_OFS_LATENCY: next_s.latency = avs_writedata_i[7:0];
                default:             next_s.cfg     = s.cfg;
            endcase
        end
        // Clear first so that an event in the same cycle still lands
        if (rd_clear)
        begin
            next_s.status = `TAPECS_RST_BYTE;
        end
        if (any_hit)
        begin
            if (s.cfg[`TAPECS_CFG_LATCH] && s.status[`TAPECS_ST_ACTIVE] && !rd_clear)
            begin
                next_s.status = s.status;
            end
            else
            begin
                next_s.status = fresh;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s        <= '0;
            s.wait_n <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign avs_readdata_o    = {24'h00_0000, s.rdata};
    assign avs_waitrequest_o = s.wait_n;
    // Interrupt is the active flag itself, so a status read drops it unless an enabled event lands in the same cycle
    assign tap_irq_o         = s.status[`TAPECS_ST_ACTIVE];

    // ============================================================
    // Assertions
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    logic rd_clear_q;
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rd_clear_q <= 1'b0;
        end
        else
        begin
            rd_clear_q <= rd_clear;
        end
    end

    cfg_write_a: assert property (
        (wr_done && avs_address_i == `TAPECS_OFS_CFG)
        |=> (s.cfg == $past(avs_writedata_i[7:0])))
        else $error("config write not stored");

    thr_top_a: assert property (
        (done && avs_read_i && avs_address_i inside {`TAPECS_OFS_THR_X,
            `TAPECS_OFS_THR_Y, `TAPECS_OFS_THR_Z}) |-> (avs_readdata_o[7] == 1'b0))
        else $error("threshold bit 7 not zero");

    gated_axis_a: assert property (
        $rose(s.status[`TAPECS_ST_HIT_LSB])
        |-> $past(det_single[0] & s.cfg[0] | det_double[0] & s.cfg[1]))
        else $error("x hit without enabled event");

    read_clear_a: assert property (
        (rd_clear && !any_hit) |=> (s.status == 8'h00 && !tap_irq_o))
        else $error("status read did not clear");

    latch_freeze_a: assert property (
        (s.status[7] && s.cfg[6] && !rd_clear && !wr_done) |=> $stable(s.status))
        else $error("latched status changed");

    event_irq_a: assert property (
        any_hit |=> tap_irq_o)
        else $error("enabled event raised no interrupt");

    double_flag_a: assert property (
        (any_hit && !(s.cfg[6] && s.status[7] && !rd_clear))
        |=> (s.status[3] == $past(|hit_double)))
        else $error("double flag wrong");

    follow_new_a: assert property (
        (any_hit && !s.cfg[6]) |=> (s.status[6:4] == $past(hit_axis)))
        else $error("status did not follow latest event");

    bus_answer_a: assert property (
        (req && s.wait_n) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest timing wrong");

    // ============================================================
    // Register storage and waitrequest checks
    thr_x_write_a: assert property (
        (wr_done && avs_address_i == `TAPECS_OFS_THR_X)
        |=> (s.thr_x == $past(avs_writedata_i[6:0])))
        else $error("x threshold write not stored");

    thr_y_write_a: assert property (
        (wr_done && avs_address_i == `TAPECS_OFS_THR_Y)
        |=> (s.thr_y == $past(avs_writedata_i[6:0])))
        else $error("y threshold write not stored");

    thr_z_write_a: assert property (
        (wr_done && avs_address_i == `TAPECS_OFS_THR_Z)
        |=> (s.thr_z == $past(avs_writedata_i[6:0])))
        else $error("z threshold write not stored");

    lane_guard_a: assert property (
        (done && avs_write_i && !avs_byteenable_i[0]) |=> $stable(s.cfg))
        else $error("config changed without byte enable");

    idle_wait_a: assert property (
        !req |=> avs_waitrequest_o)
        else $error("waitrequest low without request");

    // Own disable so that the check runs while reset is high
    reset_clear_a: assert property (
        @(posedge core_clk_i) disable iff (1'b0)
        rst_i |=> (s.cfg == 8'h00 && s.thr_x == 7'h00 && s.thr_y == 7'h00
            && s.thr_z == 7'h00 && s.status == 8'h00 && avs_waitrequest_o))
        else $error("reset left a register set");

    // ============================================================
    // Status checks
    status_quiet_a: assert property (
        (!any_hit && !rd_clear) |=> $stable(s.status))
        else $error("status changed without enabled event");

    double_enabled_a: assert property (
        $rose(s.status[`TAPECS_ST_DOUBLE])
        |-> $past(|(det_double & {s.cfg[5], s.cfg[3], s.cfg[1]})))
        else $error("double flag without enabled double event");

    sign_bits_a: assert property (
        (any_hit && !(s.cfg[6] && s.status[7] && !rd_clear))
        |=> (s.status[2:0] == $past(hit_axis & det_sign)))
        else $error("sign bits wrong");

    idle_clear_a: assert property (
        !s.status[`TAPECS_ST_ACTIVE] |-> (s.status[6:0] == 7'h00))
        else $error("status bits set without active flag");

    latch_hold_a: assert property (
        (s.cfg[6] && s.status[7] && !rd_clear) |=> tap_irq_o)
        else $error("latched event dropped before read");

    single_cov_c: cover property (any_hit && !(|hit_double));
    double_cov_c: cover property (any_hit && (|hit_double));
    clear_cov_c:  cover property (rd_clear_q && !tap_irq_o ##[1:50] tap_irq_o);
    latch_cov_c:  cover property (any_hit && s.cfg[6] && s.status[7]);
    race_cov_c:   cover property (rd_clear && any_hit);

endmodule : tapecs_top
`default_nettype wire

// ==== tb_tapecs_top.sv ====
/*
 Self-checking testbench of the tap event configuration and status bank.
 Assumes tapecs_top with its default parameters; the bench drives the
 Avalon-MM slave and the sample stream itself, with no partner model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tapecs_cfg.svh"

module tb_tapecs_top;
    import tapecs_pkg::*;

    // ============================================================
    // Signals
    logic        core_clk_i        = 1'b0;
    logic        rst_i             = 1'b1;
    logic [5:0]  avs_address_i     = 6'h00;
    logic        avs_read_i        = 1'b0;
    logic        avs_write_i       = 1'b0;
    logic [31:0] avs_writedata_i   = 32'h0;
    logic [3:0]  avs_byteenable_i  = 4'hf;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        sample_valid_i    = 1'b0;
    logic [7:0]  accel_x_i         = 8'h00;
    logic [7:0]  accel_y_i         = 8'h00;
    logic [7:0]  accel_z_i         = 8'h00;
    logic        tap_irq_o;
    int          err_total         = 0;
    int          n_tests           = 0;

    always #12.5 core_clk_i = ~core_clk_i;

    tapecs_top tapecs_top_inst (
        .core_clk_i        (core_clk_i),
        .rst_i             (rst_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .sample_valid_i    (sample_valid_i),
        .accel_x_i         (accel_x_i),
        .accel_y_i         (accel_y_i),
        .accel_z_i         (accel_z_i),
        .tap_irq_o         (tap_irq_o)
    );

    // ============================================================
    // Common tasks
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One transfer; the request stands until waitrequest is sampled low
    task bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
             input logic [3:0] be, output logic [7:0] q);
        int k;
        k = 0;
        @(posedge core_clk_i);
        avs_address_i    <= a;
        avs_writedata_i  <= {24'h0, d};
        avs_byteenable_i <= be;
        avs_read_i       <= ~wr;
        avs_write_i      <= wr;
        do
        begin
            @(posedge core_clk_i);
            k++;
        end
        while (avs_waitrequest_o !== 1'b0 && k < 40);
        if (avs_waitrequest_o !== 1'b0)
        begin
            err_total++;
            end_of_test();
        end
        q = avs_readdata_o[7:0];
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask : wr

    task rd_chk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, 4'hf, q);
        chk(q, exp);
    endtask : rd_chk

    // Samples are spaced two cycles apart so every strobe is one cycle
    task smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
        @(posedge core_clk_i);
        sample_valid_i <= 1'b1;
        accel_x_i      <= x;
        accel_y_i      <= y;
        accel_z_i      <= z;
        @(posedge core_clk_i);
        sample_valid_i <= 1'b0;
    endtask : smp

    task quiet(input int n);
        repeat (n) smp(8'h00, 8'h00, 8'h00);
    endtask : quiet

    task tap(input int ax, input logic [7:0] v, input int n);
        repeat (n) smp(ax == 0 ? v : 8'h00, ax == 1 ? v : 8'h00, ax == 2 ? v : 8'h00);
        smp(8'h00, 8'h00, 8'h00);
    endtask : tap

    task setup(input logic [7:0] cfg, input logic [7:0] thr,
               input logic [7:0] tlim, input logic [7:0] lat);
        wr(`TAPECS_OFS_CFG, cfg);
        wr(`TAPECS_OFS_THR_X, thr);
        wr(`TAPECS_OFS_THR_Y, thr);
        wr(`TAPECS_OFS_THR_Z, thr);
        wr(`TAPECS_OFS_TLIMIT, tlim);
        wr(`TAPECS_OFS_LATENCY, lat);
    endtask : setup

    // ============================================================
    // Scenarios
    task t_regs;
        logic [7:0] q;
        for (int a = 'h21; a <= 'h27; a++)
            rd_chk(a[5:0], 8'h00);
        wr(`TAPECS_OFS_THR_X, 8'hff);
        wr(`TAPECS_OFS_THR_Y, 8'hd5);
        wr(`TAPECS_OFS_THR_Z, 8'haa);
        rd_chk(`TAPECS_OFS_THR_X, 8'h7f);
        rd_chk(`TAPECS_OFS_THR_Y, 8'h55);
        rd_chk(`TAPECS_OFS_THR_Z, 8'h2a);
        bus(1'b1, `TAPECS_OFS_CFG, 8'h3f, 4'h0, q);
        rd_chk(`TAPECS_OFS_CFG, 8'h00);
        wr(`TAPECS_OFS_CFG, 8'hff);
        rd_chk(`TAPECS_OFS_CFG, 8'hff);
        wr(`TAPECS_OFS_STATUS, 8'hff);
        rd_chk(`TAPECS_OFS_STATUS, 8'h00);
        wr(6'h3f, 8'h5a);
        rd_chk(6'h3f, 8'h00);
        $display("register test done");
    endtask : t_regs

    // Every axis and both signs; with every enable but the x single one set, an x single tap must not report
    task t_single;
        for (int ax = 0; ax < 3; ax++)
            for (int sg = 0; sg < 2; sg++)
            begin
                setup(8'h01 << (2 * ax), 8'h10, 8'h04, 8'h02);
                tap(ax, sg ? 8'he0 : 8'h20, 1);
                quiet(4);
                chk({7'h0, tap_irq_o}, 8'h01);
                rd_chk(`TAPECS_OFS_STATUS, 8'h80 | (8'h10 << ax) | (sg[7:0] << ax));
                // Interrupt drops at the edge that takes the read
                @(negedge core_clk_i);
                chk({7'h0, tap_irq_o}, 8'h00);
                rd_chk(`TAPECS_OFS_STATUS, 8'h00);
                quiet(30);
            end
        setup(8'h3e, 8'h10, 8'h04, 8'h02);
        tap(0, 8'h20, 1);
        quiet(30);
        chk({7'h0, tap_irq_o}, 8'h00);
        rd_chk(`TAPECS_OFS_STATUS, 8'h00);
        $display("single tap test done");
    endtask : t_single

    // Second pulse inside latency, third inside the window after it
    task t_double(input logic double_tap_abort, input logic [7:0] exp);
        setup({double_tap_abort, 7'h02}, 8'h10, 8'h04, 8'h06);
        tap(0, 8'h20, 1);
        quiet(1);
        tap(0, 8'h20, 1);
        quiet(6);
        tap(0, 8'he0, 1);
        quiet(4);
        rd_chk(`TAPECS_OFS_STATUS, exp);
        quiet(40);
        rd_chk(`TAPECS_OFS_STATUS, 8'h00);
        $display("double tap test done");
    endtask : t_double

    // Threshold boundary on magnitude and an overlong pulse
    task t_reject;
        setup(8'h01, 8'h40, 8'h02, 8'h02);
        tap(0, 8'h41, 6);
        quiet(30);
        rd_chk(`TAPECS_OFS_STATUS, 8'h00);
        tap(0, 8'h40, 1);
        quiet(30);
        tap(0, 8'hc0, 1);
        quiet(30);
        rd_chk(`TAPECS_OFS_STATUS, 8'h00);
        tap(0, 8'hbf, 1);
        quiet(4);
        rd_chk(`TAPECS_OFS_STATUS, 8'h91);
        quiet(30);
        $display("threshold test done");
    endtask : t_reject

    task t_latch(input logic le, input logic [7:0] exp);
        setup({1'b0, le, 6'h05}, 8'h10, 8'h04, 8'h02);
        tap(0, 8'h20, 1);
        quiet(6);
        tap(1, 8'he0, 1);
        quiet(6);
        chk({7'h0, tap_irq_o}, 8'h01);
        rd_chk(`TAPECS_OFS_STATUS, exp);
        quiet(30);
        $display("latch test done");
    endtask : t_latch

    // Reset in mid-run with a latched event pending
    task t_reset;
        setup(8'h41, 8'h10, 8'h04, 8'h02);
        tap(0, 8'h20, 1);
        quiet(4);
        chk({7'h0, tap_irq_o}, 8'h01);
        rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        chk({7'h0, tap_irq_o}, 8'h00);
        rd_chk(`TAPECS_OFS_CFG, 8'h00);
        rd_chk(`TAPECS_OFS_THR_X, 8'h00);
        rd_chk(`TAPECS_OFS_STATUS, 8'h00);
        $display("reset test done");
    endtask : t_reset

    // ============================================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge core_clk_i);
        chk({7'h0, tap_irq_o}, 8'h00);
        rst_i <= 1'b0;
        t_regs();
        t_single();
        t_double(1'b0, 8'h99);
        t_double(1'b1, 8'h00);
        t_reject();
        t_latch(1'b1, 8'h90);
        t_latch(1'b0, 8'ha2);
        t_reset();
        end_of_test();
    end

endmodule : tb_tapecs_top

`default_nettype wire
